// ===== src/pms_regs.sv
`timescale 1ns/10ps
// How it works
// - Completed negotiation writes resolved mode as one-hot bits 15 to 12.
// - Mode bits are meaningless outside negotiation mode; software ignores them.
// - All four mode bits read one after reset until results arrive.
// - Bits 11 to 9 read zero and writes to them are dropped.
// - Frame address travels most significant bit first, starting at bit four.
// - Bits 3 to 0 show the negotiation progress code.
// - Monitor field is read-only, resets to zero, follows the engine continuously.
module pms_regs (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [4:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic [4:0] strap_addr_pins,
    input wire logic an_enabled,
    input wire logic an_done,
    input wire pms_pkg::pms_mode_e an_mode,
    input wire logic [3:0] an_monitor,
    input wire logic frame_addr_bit,
    input wire logic frame_addr_valid,
    input wire logic frame_addr_start,
    output logic addr_match,
    output logic [4:0] mgmt_station_addr,
    output logic irq
);
    import pms_pkg::*;

    pms_sync_if sif ();

    logic [3:0] mode_r;
    logic [3:0] mode_nxt;
    logic [4:0] addr_r;
    logic [4:0] addr_nxt;
    logic [3:0] mon_r;
    logic [3:0] mon_nxt;
    logic strap_load_r;
    logic strap_load_nxt;
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;
    logic [2:0] irq_stat_r;
    logic [2:0] irq_stat_nxt;
    logic [2:0] irq_en_r;
    logic [2:0] irq_en_nxt;
    logic irq_r;
    logic irq_nxt;
    logic [4:0] shift_r;
    logic [4:0] shift_nxt;
    logic [2:0] cnt_r;
    logic [2:0] cnt_nxt;
    logic match_r;
    logic match_nxt;
    logic [3:0] mode_hot;
    logic [2:0] events;
    logic wr_status;
    logic [15:0] status_word;

    // The strap pins are not on the management clock, so they are synchronised first.
    assign sif.strap_raw = strap_addr_pins;
    pms_sync u_sync (
        .mclk(mclk),
        .rst_b(rst_b),
        .sif(sif)
    );

    assign wr_status = reg_wr && (reg_addr == PMS_OFF_STATUS);

    // One-hot decode of the resolved mode.
    always_comb begin
        mode_hot = 4'h0;
        unique case (an_mode)
            PMS_FAST_FULL: mode_hot[PMS_POS_FAST_FULL - PMS_POS_SLOW_HALF] = 1'b1;
            PMS_FAST_HALF: mode_hot[PMS_POS_FAST_HALF - PMS_POS_SLOW_HALF] = 1'b1;
            PMS_SLOW_FULL: mode_hot[PMS_POS_SLOW_FULL - PMS_POS_SLOW_HALF] = 1'b1;
            PMS_SLOW_HALF: mode_hot[0] = 1'b1;
        endcase
    end

    // Status fields. Mode bits only follow a finished negotiation; when negotiation is
    // disabled they simply keep a stale value, which software must not trust.
    always_comb begin
        mode_nxt = mode_r;
        mon_nxt = an_monitor;
        addr_nxt = addr_r;
        if (an_enabled && an_done) begin
            mode_nxt = mode_hot;
        end
        // The strap value is taken on the third edge after release, once the synchroniser is filled.
        if (strap_load_r) begin
            addr_nxt = sif.strap_sync;
        end else if (wr_status) begin
            addr_nxt = reg_wdata[PMS_POS_ADDR_LO +: 5];
        end
    end

    // Strap capture strobe after reset release, delayed for the synchroniser.
    logic [1:0] rel_r;
    logic [1:0] rel_nxt;
    always_comb begin
        rel_nxt = {rel_r[0], 1'b1};
        strap_load_nxt = rel_r[0] && !rel_r[1];
    end

    // Register of the status fields.
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            mode_r <= PMS_RST_MODE;
            mon_r <= PMS_RST_MON;
            addr_r <= 5'h00;
            strap_load_r <= 1'b0;
            rel_r <= 2'b00;
        end else begin
            mode_r <= mode_nxt;
            mon_r <= mon_nxt;
            addr_r <= addr_nxt;
            strap_load_r <= strap_load_nxt;
            rel_r <= rel_nxt;
        end
    end

    // Reserved bits are tied to zero in the read word.
    assign status_word = {mode_r, 3'h0, addr_r, mon_r};

    // Interrupt events; set wins over a clear in the same cycle.
    assign events[PMS_IRQ_DONE] = an_enabled && an_done && (mode_hot != mode_r);
    assign events[PMS_IRQ_MON] = (an_monitor != mon_r);
    assign events[PMS_IRQ_ADDR] = wr_status || strap_load_r;
    always_comb begin
        irq_stat_nxt = irq_stat_r;
        irq_en_nxt = irq_en_r;
        if (reg_wr && (reg_addr == PMS_OFF_IRQ_CLR)) begin
            irq_stat_nxt = irq_stat_nxt & ~reg_wdata[2:0];
        end
        if (reg_wr && (reg_addr == PMS_OFF_IRQ_EN)) begin
            irq_en_nxt = reg_wdata[2:0];
        end
        irq_stat_nxt = irq_stat_nxt | events;
        irq_nxt = |(irq_stat_nxt & irq_en_nxt);
    end

    // Register of the interrupt state.
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            irq_stat_r <= PMS_IRQ_RST;
            irq_en_r <= PMS_IRQ_RST;
            irq_r <= 1'b0;
        end else begin
            irq_stat_r <= irq_stat_nxt;
            irq_en_r <= irq_en_nxt;
            irq_r <= irq_nxt;
        end
    end

    // Read mux; unmapped offsets and the write-only clear register read zero.
    always_comb begin
        rdata_nxt = 16'h0000;
        if (reg_rd) begin
            unique case (reg_addr)
                PMS_OFF_STATUS: rdata_nxt = status_word;
                PMS_OFF_IRQ_STAT: rdata_nxt = {13'h0000, irq_stat_r};
                PMS_OFF_IRQ_EN: rdata_nxt = {13'h0000, irq_en_r};
                default: rdata_nxt = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            rdata_r <= 16'h0000;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // Frame address shifter: bit four arrives first, so each bit shifts in at the bottom.
    // The compare uses the live field, so a rewrite made before a frame's last bit already applies to that frame.
    always_comb begin
        shift_nxt = shift_r;
        cnt_nxt = cnt_r;
        match_nxt = match_r;
        if (frame_addr_start) begin
            cnt_nxt = 3'h0;
            match_nxt = 1'b0;
        end else if (frame_addr_valid && (cnt_r != 3'h5)) begin
            shift_nxt = {shift_r[3:0], frame_addr_bit};
            cnt_nxt = cnt_r + 3'h1;
            if (cnt_r == 3'h4) begin
                match_nxt = ({shift_r[3:0], frame_addr_bit} == addr_r);
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            shift_r <= 5'h00;
            cnt_r <= 3'h0;
            match_r <= 1'b0;
        end else begin
            shift_r <= shift_nxt;
            cnt_r <= cnt_nxt;
            match_r <= match_nxt;
        end
    end

    assign reg_rdata = rdata_r;
    assign mgmt_station_addr = addr_r;
    assign addr_match = match_r;
    assign irq = irq_r;

    // Assertions.
    a_mode_reset_ones: assert property (@(posedge mclk) $rose(rst_b) |-> mode_r == 4'hf)
        else $error("mode bits not all one after reset");
    a_mode_onehot: assert property (@(posedge mclk) disable iff (!rst_b)
        (an_enabled && an_done) |=> $onehot(mode_r))
        else $error("resolved mode not one-hot");
    a_mode_hold: assert property (@(posedge mclk) disable iff (!rst_b)
        !(an_enabled && an_done) |=> $stable(mode_r))
        else $error("mode bits changed without negotiation result");
    a_reserved_zero: assert property (@(posedge mclk) disable iff (!rst_b)
        $past(reg_rd) && $past(reg_addr) == PMS_OFF_STATUS |-> reg_rdata[11:9] == 3'h0)
        else $error("reserved bits not zero");
    a_addr_write: assert property (@(posedge mclk) disable iff (!rst_b)
        wr_status && !strap_load_r |=> addr_r == $past(reg_wdata[8:4]))
        else $error("address write lost");
    a_mon_follow: assert property (@(posedge mclk) disable iff (!rst_b)
        1'b1 |=> mon_r == $past(an_monitor))
        else $error("monitor code not tracking");
    a_match_addr: assert property (@(posedge mclk) disable iff (!rst_b)
        frame_addr_valid && !frame_addr_start && cnt_r == 3'h4 && ({shift_r[3:0], frame_addr_bit} != addr_r)
        |=> !addr_match)
        else $error("match on wrong address");
    a_irq_level: assert property (@(posedge mclk) disable iff (!rst_b)
        ##1 irq == |($past(irq_stat_nxt) & $past(irq_en_nxt)))
        else $error("interrupt level wrong");
endmodule

// ===== src/pms_pkg.sv
package pms_pkg;
    // Register index and field layout of the resolved mode and address status word.
    localparam logic [4:0] PMS_OFF_STATUS = 5'h11;
    localparam logic [4:0] PMS_OFF_IRQ_STAT = 5'h18;
    localparam logic [4:0] PMS_OFF_IRQ_EN = 5'h19;
    localparam logic [4:0] PMS_OFF_IRQ_CLR = 5'h1a;
    localparam int PMS_POS_FAST_FULL = 15;
    localparam int PMS_POS_FAST_HALF = 14;
    localparam int PMS_POS_SLOW_FULL = 13;
    localparam int PMS_POS_SLOW_HALF = 12;
    localparam int PMS_POS_ADDR_LO = 4;
    localparam int PMS_POS_MON_LO = 0;
    localparam logic [3:0] PMS_RST_MODE = 4'hf;
    localparam logic [3:0] PMS_RST_MON = 4'h0;
    localparam logic [2:0] PMS_IRQ_RST = 3'h0;
    // Interrupt status bits: negotiation done with a changed resolved mode, monitor code changed, address rewritten.
    localparam int PMS_IRQ_DONE = 0;
    localparam int PMS_IRQ_MON = 1;
    localparam int PMS_IRQ_ADDR = 2;
    // Negotiation monitor codes.
    localparam logic [3:0] PMS_MON_IDLE = 4'h0;
    localparam logic [3:0] PMS_MON_ACK_OK = 4'h2;
    localparam logic [3:0] PMS_MON_ACK_FAIL = 4'h3;
    localparam logic [3:0] PMS_MON_CONS_OK = 4'h4;
    localparam logic [3:0] PMS_MON_CONS_FAIL = 4'h5;
    localparam logic [3:0] PMS_MON_PD_OK = 4'h6;
    localparam logic [3:0] PMS_MON_PD_FAIL = 4'h7;
    localparam logic [3:0] PMS_MON_DONE = 4'h8;
    // Resolved mode encoding on the negotiation engine input.
    typedef enum logic [1:0] {
        PMS_SLOW_HALF = 2'b00,
        PMS_SLOW_FULL = 2'b01,
        PMS_FAST_HALF = 2'b10,
        PMS_FAST_FULL = 2'b11
    } pms_mode_e;
endpackage

// ===== src/pms_sync_if.sv
`timescale 1ns/10ps
// Bundle of pins that cross into the management clock domain.
interface pms_sync_if;
    logic [4:0] strap_raw;
    logic [4:0] strap_sync;
    modport src (output strap_raw, input strap_sync);
    modport dst (input strap_raw, output strap_sync);
endinterface

// ===== src/pms_sync.sv
`timescale 1ns/10ps
// Two-flop synchroniser for the address strap pins.
module pms_sync (
    input wire logic mclk,
    input wire logic rst_b,
    pms_sync_if.dst sif
);
    import pms_pkg::*;
    logic [4:0] meta_r;
    logic [4:0] meta_nxt;
    logic [4:0] sync_r;
    logic [4:0] sync_nxt;

    // Only the second stage is visible outside.
    always_comb begin
        meta_nxt = sif.strap_raw;
        sync_nxt = meta_r;
    end

    // Registering of both stages.
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            meta_r <= 5'h00;
            sync_r <= 5'h00;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign sif.strap_sync = sync_r;
endmodule

// ===== tb/pms_mgmt_ctrl.sv
`timescale 1ns/10ps
// Stand-in for the station management controller that heads each frame with a target address.
module pms_mgmt_ctrl (
    input wire logic mclk,
    input wire logic send,
    input wire logic [4:0] target,
    output logic start,
    output logic valid,
    output logic bit_o
);
    logic [4:0] sh;
    initial begin
        start = 1'b0;
        valid = 1'b0;
        bit_o = 1'b0;
    end
    // Outside a frame the data line shows the inverse of the last bit, so no stale value can pass.
    always begin
        @(posedge mclk);
        if (send) begin
            sh = target;
            start <= 1'b1;
            @(posedge mclk);
            start <= 1'b0;
            for (int i = 4; i >= 0; i--) begin
                valid <= 1'b1;
                bit_o <= sh[i];
                @(posedge mclk);
            end
            valid <= 1'b0;
            bit_o <= ~sh[0];
        end
    end
endmodule

// ===== tb/testbench.sv
`timescale 1ns/10ps
// Self-checking bench for the resolved mode and address status word.
module testbench;
    import pms_pkg::*;
    logic mclk, rst_b, reg_wr, reg_rd, an_enabled, an_done, send, irq;
    logic f_start, f_valid, f_bit, addr_match;
    logic [4:0] reg_addr, strap_addr_pins, target, mgmt_station_addr, addr_x;
    logic [15:0] reg_wdata, reg_rdata, rd_val;
    logic [3:0] an_monitor, mode_x, mon_x;
    pms_mode_e an_mode;
    int n_fail, comparisons;
    localparam logic [3:0] MON_CODES [8] = '{PMS_MON_IDLE, PMS_MON_ACK_OK, PMS_MON_ACK_FAIL, PMS_MON_CONS_OK,
        PMS_MON_CONS_FAIL, PMS_MON_PD_OK, PMS_MON_PD_FAIL, PMS_MON_DONE};

    pms_regs u_dut (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .strap_addr_pins(strap_addr_pins), .an_enabled(an_enabled),
        .an_done(an_done), .an_mode(an_mode), .an_monitor(an_monitor), .frame_addr_bit(f_bit),
        .frame_addr_valid(f_valid), .frame_addr_start(f_start), .addr_match(addr_match),
        .mgmt_station_addr(mgmt_station_addr), .irq(irq));
    pms_mgmt_ctrl u_ctrl (.mclk(mclk), .send(send), .target(target), .start(f_start), .valid(f_valid),
        .bit_o(f_bit));

    // Free-running 25 MHz clock.
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so they are caught just past that edge.
    task automatic rd(input logic [4:0] a);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        rd_val = reg_rdata;
    endtask

    task automatic chk_status();
        rd(PMS_OFF_STATUS);
        chk(rd_val, {mode_x, 3'h0, addr_x, mon_x});
    endtask

    task automatic negotiate(input logic en, input pms_mode_e m);
        @(posedge mclk);
        an_enabled <= en;
        an_mode <= m;
        an_done <= 1'b1;
        @(posedge mclk);
        an_done <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask

    task automatic t_modes();
        for (int m = 0; m < 4; m++) begin
            negotiate(1'b1, pms_mode_e'(m));
            mode_x = 4'h1 << m;
            chk_status();
        end
        negotiate(1'b0, PMS_SLOW_HALF);
        chk_status();
    endtask

    task automatic t_write();
        wr(PMS_OFF_STATUS, 16'hffff);
        addr_x = 5'h1f;
        chk_status();
        wr(PMS_OFF_STATUS, 16'h0030);
        addr_x = 5'h03;
        chk_status();
        chk({11'h0, mgmt_station_addr}, 16'h0003);
    endtask

    task automatic t_monitor();
        foreach (MON_CODES[i]) begin
            @(posedge mclk);
            an_monitor <= MON_CODES[i];
            mon_x = MON_CODES[i];
            repeat (2) @(posedge mclk);
            chk_status();
        end
    endtask

    // Match is set six cycles after the frame start and holds until the next start.
    task automatic frame(input logic [4:0] t, input logic exp);
        @(posedge mclk);
        send <= 1'b1;
        target <= t;
        @(posedge mclk);
        send <= 1'b0;
        repeat (7) @(posedge mclk);
        #1;
        chk({15'h0, addr_match}, {15'h0, exp});
    endtask

    task automatic t_frames();
        frame(5'h03, 1'b1);
        frame(5'h18, 1'b0);
        wr(PMS_OFF_STATUS, 16'h0180);
        addr_x = 5'h18;
        frame(5'h03, 1'b0);
        frame(5'h18, 1'b1);
    endtask

    task automatic t_irq();
        wr(PMS_OFF_IRQ_CLR, 16'h0007);
        wr(PMS_OFF_IRQ_EN, 16'h0001);
        rd(PMS_OFF_IRQ_STAT);
        chk(rd_val, 16'h0000);
        negotiate(1'b1, PMS_SLOW_HALF);
        mode_x = 4'h1;
        chk({15'h0, irq}, 16'h0001);
        rd(PMS_OFF_IRQ_STAT);
        chk(rd_val, 16'h0001);
        wr(PMS_OFF_IRQ_EN, 16'h0000);
        repeat (2) @(posedge mclk);
        chk({15'h0, irq}, 16'h0000);
        wr(PMS_OFF_IRQ_CLR, 16'h0001);
        rd(PMS_OFF_IRQ_STAT);
        chk(rd_val, 16'h0000);
        rd(PMS_OFF_IRQ_CLR);
        chk(rd_val, 16'h0000);
        rd(5'h05);
        chk(rd_val, 16'h0000);
        // An address rewrite and a monitor change must each leave their own sticky bit.
        wr(PMS_OFF_STATUS, 16'h0180);
        @(posedge mclk);
        an_monitor <= PMS_MON_IDLE;
        mon_x = PMS_MON_IDLE;
        rd(PMS_OFF_IRQ_STAT);
        chk(rd_val, 16'h0006);
        chk_status();
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Main sequence: reset, then every scenario in turn.
    initial begin
        {rst_b, reg_wr, reg_rd, an_enabled, an_done, send} = 6'h00;
        {reg_addr, target, reg_wdata, an_monitor} = '0;
        an_mode = PMS_SLOW_HALF;
        strap_addr_pins = 5'h15;
        {addr_x, mode_x, mon_x} = {5'h15, PMS_RST_MODE, PMS_RST_MON};
        repeat (5) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (4) @(posedge mclk);
        chk_status();
        t_modes();
        t_write();
        t_monitor();
        t_frames();
        t_irq();
        finish_test();
    end

    // The scenarios take well under ten thousand cycles; this cuts a hang short.
    initial begin
        #400000;
        n_fail++;
        finish_test();
    end
endmodule
